// File: inc/mmb_pkg.sv
// Shared constants for the maintenance monitor bank
package mmb_pkg;

  // Register indices; the byte address of each is four times its index
  localparam logic [10:0] IDX_DISPLAY_SEGMENT_TEST  = 11'h03c;
  localparam logic [10:0] IDX_OPERATING_HOURS       = 11'h04c;
  localparam logic [10:0] IDX_ENERGY_LOW_DIGITS     = 11'h05c;
  localparam logic [10:0] IDX_ENERGY_HIGH_DIGITS    = 11'h05d;
  localparam logic [10:0] IDX_FAN_HOURS             = 11'h067;
  localparam logic [10:0] IDX_HEATSINK_TEMPERATURE  = 11'h068;
  localparam logic [10:0] IDX_RUN_COMMAND_COUNT     = 11'h075;
  localparam logic [10:0] IDX_CAPACITOR_WEAR_PCT    = 11'h07c;
  localparam logic [10:0] IDX_FAN_WEAR_PCT          = 11'h07e;
  localparam logic [10:0] IDX_PEAK_CURRENT_HOLD     = 11'h7cf;
  localparam logic [10:0] IDX_BYPASS_RELAY_WEAR_PCT = 11'h7d6;
  localparam logic [10:0] IDX_POWER_SWITCH_WEAR_PCT = 11'h7d7;
  // Maintenance parameter register (write-one reset pulses, count condition)
  localparam logic [10:0] IDX_MAINT_CONTROL         = 11'h7e0;

  // Address slicing of the 32-bit byte address
  localparam int ADDR_IDX_LSB = 2;
  localparam int ADDR_IDX_MSB = 12;

  // Bit positions inside the maintenance parameter register
  localparam int CTL_OPERATING_HOURS_RESET   = 0;
  localparam int CTL_RUN_COUNT_RESET         = 1;
  localparam int CTL_FAN_TIME_RESET          = 2;
  localparam int CTL_CAPACITOR_WEAR_RESET    = 3;
  localparam int CTL_BYPASS_RELAY_WEAR_RESET = 4;
  localparam int CTL_POWER_SWITCH_WEAR_RESET = 5;
  localparam int CTL_COUNT_CONDITION         = 8;

  // Counter widths and limits
  localparam int          HOURS_W      = 17;
  localparam logic [16:0] HOURS_MAX    = 17'h1869f;  // 99999
  localparam int          RUNCNT_W     = 16;
  localparam logic [15:0] RUNCNT_MAX   = 16'hffff;   // 65535
  localparam int          PCT_W        = 16;
  localparam logic [15:0] PCT_MAX      = 16'h270f;   // Saturation at 9999 %
  localparam int          ENERGY_LO_W  = 14;
  localparam logic [13:0] ENERGY_LO_MAX = 14'h270f;  // 999.9 kWh in 0.1 kWh units

  // Count condition encodings
  localparam logic COUNT_WHEN_POWERED = 1'b0;
  localparam logic COUNT_WHEN_RUNNING = 1'b1;

  // Display test pattern: every segment of every digit lit
  localparam logic [15:0] LED_ALL_SEGMENTS = 16'h8888;

  // Analog output: full scale code stands for 10 V = motor rated current
  localparam int          ANALOG_W   = 12;
  localparam logic [11:0] ANALOG_FS  = 12'hfff;

  // AHB-Lite encodings
  localparam logic       HRESP_OKAY = 1'b0;
  localparam logic [1:0] HTRANS_IDLE = 2'h0;

endpackage

// File: verilog/mmb_event_counter.sv
`timescale 1ns/1ps
// Counter with synchronous clear, wrapping or saturating at a limit
module mmb_event_counter #(
  parameter int               WIDTH = 16,
  parameter logic [WIDTH-1:0] LIMIT = '1,
  parameter bit               SAT   = 1'b0
) (
  // Clock, reset, enable
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_ce,
  // Control
  input  wire logic             i_clr,
  input  wire logic             i_inc,
  // Value
  output logic [WIDTH-1:0]      o_count
);

  logic [WIDTH-1:0] count_r;

  // Clear wins over a count in the same cycle, as the reset parameter is a command
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      count_r <= '0;
    end else if (i_ce) begin
      if (i_clr) begin
        count_r <= '0;
      end else if (i_inc) begin
        if (count_r >= LIMIT) begin
          count_r <= SAT ? LIMIT : '0;
        end else begin
          count_r <= count_r + 1'b1;
        end
      end
    end
  end

  assign o_count = count_r;

endmodule // mmb_event_counter

// File: verilog/mmb_energy_acc.sv
`timescale 1ns/1ps
// Nine-digit output energy total: 0.1 kWh low part, MWh high part
module mmb_energy_acc (
  // Clock, reset, enable
  input  wire logic                            i_clk,
  input  wire logic                            i_rst_n,
  input  wire logic                            i_ce,
  // One pulse per 0.1 kWh delivered
  input  wire logic                            i_tenth_kwh,
  // Split total
  output logic [mmb_pkg::ENERGY_LO_W-1:0]      o_low,
  output logic [mmb_pkg::HOURS_W-1:0]          o_high
);

  logic [mmb_pkg::ENERGY_LO_W-1:0] low_r;
  logic                            carry;

  // Low four digits roll into the MWh part every 10000 tenths
  assign carry = i_tenth_kwh && (low_r >= mmb_pkg::ENERGY_LO_MAX);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      low_r <= '0;
    end else if (i_ce && i_tenth_kwh) begin
      low_r <= carry ? '0 : low_r + 1'b1;
    end
  end

  // Upper five digits wrap after 99999 MWh
  mmb_event_counter #(
    .WIDTH (mmb_pkg::HOURS_W),
    .LIMIT (mmb_pkg::HOURS_MAX),
    .SAT   (1'b0)
  ) u_high (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_clr   (1'b0),
    .i_inc   (carry),
    .o_count (o_high)
  );

  assign o_low = low_r;

endmodule // mmb_energy_acc

// File: verilog/mmb_monitor_bank.sv
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - Operating time counts in one-hour steps and is readable.
// - Operating hours wrap from 99999 to zero and keep counting.
// - Operating hours clear through their own reset parameter bit.
// - Count condition selects counting while powered or only while running.
// - Each new run command adds one to the run command count.
// - Run command count wraps from 65535 to zero and resumes.
// - Run command count clears through its own reset parameter bit.
// - Fan hours count in one-hour steps and wrap after 99999.
// - Fan hours clear through the fan-time reset parameter.
// - Fan wear percent counts in 1% steps, cleared by fan-time reset.
// - Capacitor wear percent readable, cleared by its reset parameter.
// - Bypass relay wear percent readable, cleared by its reset parameter.
// - Power switch wear percent readable, cleared by its reset parameter.
// - Heatsink temperature reads in whole degrees Celsius.
// - Selecting the display test monitor lights every display segment.
// - Energy kept as nine digits: 0.1 kWh low part, MWh high part.
// - Peak run current held in 0.01 A; analog full scale is rated current.
module mmb_monitor_bank (
  // Clock, reset, enable
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  // AHB-Lite slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic        i_hready,
  input  wire logic [31:0] i_hwdata,
  output logic [31:0]      o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // Drive status inputs
  input  wire logic        i_hour_tick,
  input  wire logic        i_run_cmd,
  input  wire logic        i_fan_on,
  input  wire logic        i_tenth_kwh,
  input  wire logic [15:0] i_heatsink_temp,
  input  wire logic [15:0] i_out_current,
  input  wire logic [15:0] i_rated_current,
  // Wear estimator steps, one pulse per 1% of life used
  input  wire logic        i_fan_wear_step,
  input  wire logic        i_capacitor_wear_step,
  input  wire logic        i_bypass_relay_wear_step,
  input  wire logic        i_power_switch_wear_step,
  // Display and analog outputs
  output logic             o_led_all_segments,
  output logic [11:0]      o_peak_analog
);

  // Register index of a byte address; shared by the read and write decode
  function automatic logic [10:0] reg_index(input logic [31:0] addr);
    reg_index = addr[mmb_pkg::ADDR_IDX_MSB:mmb_pkg::ADDR_IDX_LSB];
  endfunction

  // True when the upper address bits are zero, inside the decoded window
  function automatic logic addr_in_window(input logic [31:0] addr);
    addr_in_window = (addr[31:mmb_pkg::ADDR_IDX_MSB+1] == '0);
  endfunction

  // Scale held current to the analog code; saturates above rated current
  function automatic logic [11:0] scale_analog(input logic [15:0] cur,
                                               input logic [15:0] rated);
    logic [27:0] prod;
    logic [27:0] quot;
    prod = 28'(cur) * 28'(mmb_pkg::ANALOG_FS);
    quot = '0;
    if (rated == '0) begin
      scale_analog = mmb_pkg::ANALOG_FS;
    end else begin
      quot = prod / 28'(rated);
      scale_analog = (quot > 28'(mmb_pkg::ANALOG_FS)) ? mmb_pkg::ANALOG_FS
                                                       : quot[11:0];
    end
  endfunction

  // Bus phase state
  logic        addr_ok;
  logic        wr_pend_r;
  logic [10:0] wr_idx_r;
  logic [31:0] hrdata_r;
  logic [10:0] rd_idx;

  // Maintenance parameter state
  logic        count_cond_r;
  logic [5:0]  clr_pulse_r;
  logic        ctl_write;

  // Monitor values
  logic [mmb_pkg::HOURS_W-1:0]     operating_hours;
  logic [mmb_pkg::HOURS_W-1:0]     fan_hours;
  logic [mmb_pkg::RUNCNT_W-1:0]    run_command_count;
  logic [mmb_pkg::PCT_W-1:0]       fan_wear_pct;
  logic [mmb_pkg::PCT_W-1:0]       capacitor_wear_pct;
  logic [mmb_pkg::PCT_W-1:0]       bypass_relay_wear_pct;
  logic [mmb_pkg::PCT_W-1:0]       power_switch_wear_pct;
  logic [mmb_pkg::ENERGY_LO_W-1:0] energy_low_digits;
  logic [mmb_pkg::HOURS_W-1:0]     energy_high_digits;
  logic [15:0]                     heatsink_temperature_r;
  logic [15:0]                     peak_current_hold_r;
  logic [11:0]                     peak_analog_r;
  logic                            led_test_r;
  logic                            run_cmd_d_r;
  logic                            run_edge;
  logic                            op_inc;

  // Address phase is taken only with a live transfer and the bus ready
  assign addr_ok = i_ce && i_hsel && i_htrans[1] && i_hready;
  assign rd_idx  = reg_index(i_haddr);

  // Zero wait states; a frozen block holds the bus off instead of dropping data
  assign o_hreadyout = i_ce;
  assign o_hresp     = mmb_pkg::HRESP_OKAY;

  // Read data are fetched in the address phase so that they stand in the data phase
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      hrdata_r <= 32'h0000_0000;
    end else if (addr_ok && !i_hwrite) begin
      hrdata_r <= 32'h0000_0000;
      if (addr_in_window(i_haddr)) begin
        case (rd_idx)
          mmb_pkg::IDX_OPERATING_HOURS:       hrdata_r <= 32'(operating_hours);
          mmb_pkg::IDX_RUN_COMMAND_COUNT:     hrdata_r <= 32'(run_command_count);
          mmb_pkg::IDX_FAN_HOURS:             hrdata_r <= 32'(fan_hours);
          mmb_pkg::IDX_FAN_WEAR_PCT:          hrdata_r <= 32'(fan_wear_pct);
          mmb_pkg::IDX_CAPACITOR_WEAR_PCT:    hrdata_r <= 32'(capacitor_wear_pct);
          mmb_pkg::IDX_BYPASS_RELAY_WEAR_PCT: hrdata_r <= 32'(bypass_relay_wear_pct);
          mmb_pkg::IDX_POWER_SWITCH_WEAR_PCT: hrdata_r <= 32'(power_switch_wear_pct);
          mmb_pkg::IDX_HEATSINK_TEMPERATURE:  hrdata_r <= 32'(heatsink_temperature_r);
          mmb_pkg::IDX_DISPLAY_SEGMENT_TEST:  hrdata_r <= 32'(mmb_pkg::LED_ALL_SEGMENTS);
          mmb_pkg::IDX_ENERGY_LOW_DIGITS:     hrdata_r <= 32'(energy_low_digits);
          mmb_pkg::IDX_ENERGY_HIGH_DIGITS:    hrdata_r <= 32'(energy_high_digits);
          mmb_pkg::IDX_PEAK_CURRENT_HOLD:     hrdata_r <= 32'(peak_current_hold_r);
          mmb_pkg::IDX_MAINT_CONTROL: begin
            hrdata_r[mmb_pkg::CTL_COUNT_CONDITION] <= count_cond_r;
          end
          default:                            hrdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign o_hrdata = hrdata_r;

  // Remember a write address for its data phase
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wr_pend_r <= 1'b0;
      wr_idx_r  <= 11'h000;
    end else if (i_ce) begin
      if (i_hready) begin
        wr_pend_r <= addr_ok && i_hwrite && addr_in_window(i_haddr);
        wr_idx_r  <= rd_idx;
      end
    end
  end

  // Only the parameter register accepts data; monitor writes fall through
  assign ctl_write = i_ce && wr_pend_r && (wr_idx_r == mmb_pkg::IDX_MAINT_CONTROL);

  // Count condition is a stored setting steering the operating-time counter
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      count_cond_r <= mmb_pkg::COUNT_WHEN_POWERED;
    end else if (ctl_write) begin
      count_cond_r <= i_hwdata[mmb_pkg::CTL_COUNT_CONDITION];
    end
  end

  // Reset parameters are write-one commands that act for one cycle, read back zero
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      clr_pulse_r <= 6'h00;
    end else if (i_ce) begin
      clr_pulse_r <= ctl_write ? i_hwdata[mmb_pkg::CTL_POWER_SWITCH_WEAR_RESET:
                                          mmb_pkg::CTL_OPERATING_HOURS_RESET] : 6'h00;
    end
  end

  // Run command edge detect; a held command counts once
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      run_cmd_d_r <= 1'b0;
    end else if (i_ce) begin
      run_cmd_d_r <= i_run_cmd;
    end
  end

  assign run_edge = i_run_cmd && !run_cmd_d_r;
  assign op_inc   = i_hour_tick &&
                    ((count_cond_r == mmb_pkg::COUNT_WHEN_POWERED) || i_run_cmd);

  // Operating hours, wrapping after 99999
  mmb_event_counter #(
    .WIDTH (mmb_pkg::HOURS_W),
    .LIMIT (mmb_pkg::HOURS_MAX),
    .SAT   (1'b0)
  ) u_operating_hours (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_clr   (clr_pulse_r[mmb_pkg::CTL_OPERATING_HOURS_RESET]),
    .i_inc   (op_inc),
    .o_count (operating_hours)
  );

  // Run command count, wrapping after 65535
  mmb_event_counter #(
    .WIDTH (mmb_pkg::RUNCNT_W),
    .LIMIT (mmb_pkg::RUNCNT_MAX),
    .SAT   (1'b0)
  ) u_run_command_count (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_clr   (clr_pulse_r[mmb_pkg::CTL_RUN_COUNT_RESET]),
    .i_inc   (run_edge),
    .o_count (run_command_count)
  );

  // Fan hours count only while the fan turns
  mmb_event_counter #(
    .WIDTH (mmb_pkg::HOURS_W),
    .LIMIT (mmb_pkg::HOURS_MAX),
    .SAT   (1'b0)
  ) u_fan_hours (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_clr   (clr_pulse_r[mmb_pkg::CTL_FAN_TIME_RESET]),
    .i_inc   (i_hour_tick && i_fan_on),
    .o_count (fan_hours)
  );

  // Wear percentages saturate so a worn part never reads as new again
  mmb_event_counter #(
    .WIDTH (mmb_pkg::PCT_W),
    .LIMIT (mmb_pkg::PCT_MAX),
    .SAT   (1'b1)
  ) u_fan_wear (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_clr   (clr_pulse_r[mmb_pkg::CTL_FAN_TIME_RESET]),
    .i_inc   (i_fan_wear_step),
    .o_count (fan_wear_pct)
  );

  mmb_event_counter #(
    .WIDTH (mmb_pkg::PCT_W),
    .LIMIT (mmb_pkg::PCT_MAX),
    .SAT   (1'b1)
  ) u_capacitor_wear (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_clr   (clr_pulse_r[mmb_pkg::CTL_CAPACITOR_WEAR_RESET]),
    .i_inc   (i_capacitor_wear_step),
    .o_count (capacitor_wear_pct)
  );

  mmb_event_counter #(
    .WIDTH (mmb_pkg::PCT_W),
    .LIMIT (mmb_pkg::PCT_MAX),
    .SAT   (1'b1)
  ) u_bypass_relay_wear (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_clr   (clr_pulse_r[mmb_pkg::CTL_BYPASS_RELAY_WEAR_RESET]),
    .i_inc   (i_bypass_relay_wear_step),
    .o_count (bypass_relay_wear_pct)
  );

  mmb_event_counter #(
    .WIDTH (mmb_pkg::PCT_W),
    .LIMIT (mmb_pkg::PCT_MAX),
    .SAT   (1'b1)
  ) u_power_switch_wear (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_clr   (clr_pulse_r[mmb_pkg::CTL_POWER_SWITCH_WEAR_RESET]),
    .i_inc   (i_power_switch_wear_step),
    .o_count (power_switch_wear_pct)
  );

  // Output energy total
  mmb_energy_acc u_energy (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_ce        (i_ce),
    .i_tenth_kwh (i_tenth_kwh),
    .o_low       (energy_low_digits),
    .o_high      (energy_high_digits)
  );

  // Heatsink sample, whole degrees, registered so a read sees a stable value
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      heatsink_temperature_r <= 16'h0000;
    end else if (i_ce) begin
      heatsink_temperature_r <= i_heatsink_temp;
    end
  end

  // Peak hold during run; never cleared by software, only by reset
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      peak_current_hold_r <= 16'h0000;
    end else if (i_ce && i_run_cmd && (i_out_current > peak_current_hold_r)) begin
      peak_current_hold_r <= i_out_current;
    end
  end

  // Analog level lags the held value by one cycle; divider kept off the bus path
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      peak_analog_r <= 12'h000;
    end else if (i_ce) begin
      peak_analog_r <= scale_analog(peak_current_hold_r, i_rated_current);
    end
  end

  assign o_peak_analog = peak_analog_r;

  // Display test stays lit from selecting its monitor until another is read
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      led_test_r <= 1'b0;
    end else if (addr_ok && !i_hwrite) begin
      led_test_r <= addr_in_window(i_haddr) &&
                    (rd_idx == mmb_pkg::IDX_DISPLAY_SEGMENT_TEST);
    end
  end

  assign o_led_all_segments = led_test_r;

endmodule // mmb_monitor_bank

// File: verif/mmb_monitor_bank_asserts.sv
`timescale 1ns/1ps
// Port-level checks on the monitor bank; it watches inputs and outputs only
module mmb_monitor_bank_asserts (
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  // Bus side
  input wire logic        i_ce,
  input wire logic        i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic        i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic        o_hresp,
  // Drive status and outputs
  input wire logic        i_run_cmd,
  input wire logic [15:0] i_heatsink_temp,
  input wire logic [15:0] i_out_current,
  input wire logic [15:0] i_rated_current,
  input wire logic        o_led_all_segments,
  input wire logic [11:0] o_peak_analog
);
  logic       rd;
  logic       low;
  logic [10:0] idx;

  // Read address phase taken, and whether it falls in the mapped window
  assign rd  = i_ce & i_hsel & i_htrans[1] & i_hready & ~i_hwrite;
  assign low = (i_haddr[31:13] == 19'h0);
  assign idx = i_haddr[12:2];

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  property p_okay;
    o_hresp == mmb_pkg::HRESP_OKAY;
  endproperty
  a_okay: assert property (p_okay) else $error("bus response not okay");

  property p_led_data;
    rd && low && idx == mmb_pkg::IDX_DISPLAY_SEGMENT_TEST
      |=> o_hrdata == {16'h0000, mmb_pkg::LED_ALL_SEGMENTS};
  endproperty
  a_led_data: assert property (p_led_data) else $error("test pattern wrong");

  property p_led_on;
    rd && low && idx == mmb_pkg::IDX_DISPLAY_SEGMENT_TEST |=> ##[0:1] o_led_all_segments;
  endproperty
  a_led_on: assert property (p_led_on) else $error("segments not lit");

  property p_led_off;
    rd && low && idx != mmb_pkg::IDX_DISPLAY_SEGMENT_TEST |=> ##[0:1] !o_led_all_segments;
  endproperty
  a_led_off: assert property (p_led_off) else $error("segments left lit");

  property p_unmapped;
    rd && !low |=> o_hrdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  // Requires a settled sample so a registered copy of the input has caught up
  property p_heat;
    rd && low && idx == mmb_pkg::IDX_HEATSINK_TEMPERATURE && $stable(i_heatsink_temp)
      && $past(i_rst_n) && $past(i_ce) |=> o_hrdata == {16'h0000, $past(i_heatsink_temp)};
  endproperty
  a_heat: assert property (p_heat) else $error("temperature read wrong");

  property p_peak_fs;
    (i_rst_n && i_run_cmd && i_ce && i_out_current == i_rated_current &&
     $stable(i_rated_current) && i_rated_current != 16'h0)[*3]
      |-> o_peak_analog == mmb_pkg::ANALOG_FS;
  endproperty
  a_peak_fs: assert property (p_peak_fs) else $error("analog not full scale");

  property p_peak_mono;
    // A reset inside the window legally drops the level, so it is left out
    (i_rst_n && $stable(i_rated_current))[*3] |-> o_peak_analog >= $past(o_peak_analog);
  endproperty
  a_peak_mono: assert property (p_peak_mono) else $error("peak analog fell");

  property p_peak_idle;
    (!i_run_cmd && $stable(i_rated_current))[*3] |-> $stable(o_peak_analog);
  endproperty
  a_peak_idle: assert property (p_peak_idle) else $error("peak moved while stopped");
endmodule // mmb_monitor_bank_asserts

bind mmb_monitor_bank mmb_monitor_bank_asserts u_chk (
  .i_clk, .i_rst_n, .i_ce, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hready, .o_hrdata,
  .o_hresp, .i_run_cmd, .i_heatsink_temp, .i_out_current, .i_rated_current,
  .o_led_all_segments, .o_peak_analog
);

// File: verif/mmb_monitor_bank_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module mmb_monitor_bank_tb;
  // Design inputs
  logic        i_clk           = 1'b0;
  logic        i_rst_n         = 1'b0;
  logic        i_ce            = 1'b1;
  logic        i_hsel          = 1'b0;
  logic [31:0] i_haddr         = 32'h0;
  logic [1:0]  i_htrans        = 2'h0;
  logic        i_hwrite        = 1'b0;
  logic [31:0] i_hwdata        = 32'h0;
  logic        i_run_cmd       = 1'b0;
  logic        i_fan_on        = 1'b0;
  logic [15:0] i_heatsink_temp = 16'h0;
  logic [15:0] i_out_current   = 16'h0;
  logic [15:0] i_rated_current = 16'h1388;
  logic [5:0]  pulse           = 6'h0;  // Hour, four wear steps, energy
  // Design outputs
  logic [31:0] o_hrdata;
  logic        o_hreadyout;
  logic        o_hresp;
  logic        o_led_all_segments;
  logic [11:0] o_peak_analog;
  // Reference model state
  int          failures        = 0;
  int          samples_checked = 0;
  int          op_h, run_n, fan_h, e_lo, e_hi, peak, cond, prev_run;
  int          wear [4];
  logic [31:0] rd;
  logic [10:0] idx_tab [12] = '{mmb_pkg::IDX_DISPLAY_SEGMENT_TEST,
    mmb_pkg::IDX_OPERATING_HOURS, mmb_pkg::IDX_ENERGY_LOW_DIGITS, mmb_pkg::IDX_ENERGY_HIGH_DIGITS,
    mmb_pkg::IDX_FAN_HOURS, mmb_pkg::IDX_HEATSINK_TEMPERATURE, mmb_pkg::IDX_RUN_COMMAND_COUNT,
    mmb_pkg::IDX_CAPACITOR_WEAR_PCT, mmb_pkg::IDX_FAN_WEAR_PCT, mmb_pkg::IDX_PEAK_CURRENT_HOLD,
    mmb_pkg::IDX_BYPASS_RELAY_WEAR_PCT, mmb_pkg::IDX_POWER_SWITCH_WEAR_PCT};

  // 10 MHz clock
  always #50 i_clk = ~i_clk;

  mmb_monitor_bank u_dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'h2), .i_hready(o_hreadyout),
    .i_hwdata(i_hwdata), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .i_hour_tick(pulse[0]), .i_run_cmd(i_run_cmd), .i_fan_on(i_fan_on),
    .i_tenth_kwh(pulse[5]), .i_heatsink_temp(i_heatsink_temp), .i_out_current(i_out_current),
    .i_rated_current(i_rated_current), .i_fan_wear_step(pulse[1]),
    .i_capacitor_wear_step(pulse[2]), .i_bypass_relay_wear_step(pulse[3]),
    .i_power_switch_wear_step(pulse[4]), .o_led_all_segments(o_led_all_segments),
    .o_peak_analog(o_peak_analog)
  );

  // Verdict and end of run
  task conclude;
    $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Bounded wait for hready sampled high at a rising edge
  task wait_ready;
    int n;
    n = 0;
    @(posedge i_clk);
    while (o_hreadyout !== 1'b1) begin
      n++;
      if (n > 20) begin
        failures++;
        $display("CHECK FAILED hready exp 1 got %b", o_hreadyout);
        conclude;
      end
      @(posedge i_clk);
    end
  endtask

  // One single AHB-Lite transfer; read data lands in rd
  task bus(input logic [31:0] a, input logic w, input logic [31:0] wd);
    i_hsel   <= 1'b1;
    i_haddr  <= a;
    i_htrans <= 2'h2;
    i_hwrite <= w;
    wait_ready;
    i_hsel   <= 1'b0;
    i_htrans <= mmb_pkg::HTRANS_IDLE;
    i_hwdata <= wd;
    wait_ready;
    rd = o_hrdata;
  endtask

  // One clock with the given pulses, model stepped from the sampled inputs
  task cyc(input logic [5:0] p);
    pulse <= p;
    @(posedge i_clk);
    if (i_ce) begin
      if (pulse[0] && (cond == 0 || i_run_cmd)) op_h = (op_h == 99999) ? 0 : op_h + 1;
      if (pulse[0] && i_fan_on) fan_h = (fan_h == 99999) ? 0 : fan_h + 1;
      for (int k = 0; k < 4; k++) if (pulse[k+1] && wear[k] < 9999) wear[k]++;
      if (i_run_cmd && !prev_run) run_n = (run_n == 65535) ? 0 : run_n + 1;
      prev_run = i_run_cmd;
      if (i_run_cmd && i_out_current > peak) peak = i_out_current;
      if (pulse[5]) begin
        e_lo = (e_lo == 9999) ? 0 : e_lo + 1;
        if (e_lo == 0) e_hi++;
      end
    end
  endtask

  function automatic logic [31:0] expv(input int k);
    case (k)
      0: expv = {16'h0000, mmb_pkg::LED_ALL_SEGMENTS};
      1: expv = 32'(op_h);
      2: expv = 32'(e_lo);
      3: expv = 32'(e_hi);
      4: expv = 32'(fan_h);
      5: expv = {16'h0000, i_heatsink_temp};
      6: expv = 32'(run_n);
      7: expv = 32'(wear[1]);
      8: expv = 32'(wear[0]);
      9: expv = 32'(peak);
      10: expv = 32'(wear[2]);
      default: expv = 32'(wear[3]);
    endcase
  endfunction

  // Read every monitor and compare with the model
  task check_all;
    for (int k = 0; k < 12; k++) begin
      bus({19'h0, idx_tab[k], 2'h0}, 1'b0, 32'h0);
      `CHK($sformatf("reg %0d", k), expv(k), rd)
    end
  endtask

  initial begin
    void'($urandom(35));
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    cyc(6'h00);
    check_all;
    $display("test reset_values done");
    // Writes to monitors are dropped; unmapped space reads zero
    for (int k = 0; k < 12; k++) bus({19'h0, idx_tab[k], 2'h0}, 1'b1, 32'hffff_ffff);
    check_all;
    bus(32'h0000_4000, 1'b0, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    bus({19'h0, mmb_pkg::IDX_DISPLAY_SEGMENT_TEST, 2'h0}, 1'b0, 32'h0);
    cyc(6'h00);
    `CHK("segments", 1'b1, o_led_all_segments)
    bus({19'h0, mmb_pkg::IDX_OPERATING_HOURS, 2'h0}, 1'b0, 32'h0);
    cyc(6'h00);
    `CHK("segments", 1'b0, o_led_all_segments)
    $display("test access done");
    // Random traffic under both count conditions, with clock-enable stalls
    for (int c = 0; c < 2; c++) begin
      cond = c;
      bus({19'h0, mmb_pkg::IDX_MAINT_CONTROL, 2'h0}, 1'b1, 32'(c) << 8);
      cyc(6'h00);
      bus({19'h0, mmb_pkg::IDX_MAINT_CONTROL, 2'h0}, 1'b0, 32'h0);
      `CHK("count_cond", 32'(c) << 8, rd)
      for (int n = 0; n < 6000; n++) begin
        i_ce            <= ($urandom % 8) != 0;
        i_run_cmd       <= 1'($urandom);
        i_fan_on        <= 1'($urandom);
        i_out_current   <= 16'($urandom);
        i_heatsink_temp <= 16'($urandom);
        cyc({5'h1f, 1'($urandom)});
      end
      i_ce <= 1'b1;
      cyc(6'h00);
      check_all;
      $display("test random_count condition %0d done", c);
    end
    // Each reset parameter clears its own monitors only
    for (int b = 0; b < 6; b++) begin
      bus({19'h0, mmb_pkg::IDX_MAINT_CONTROL, 2'h0}, 1'b1, (32'h1 << b) | (32'(cond) << 8));
      cyc(6'h00);
      cyc(6'h00);
      case (b)
        0: op_h = 0;
        1: run_n = 0;
        2: begin fan_h = 0; wear[0] = 0; end
        default: wear[b-2] = 0;
      endcase
      check_all;
    end
    $display("test clears done");
    // Run-only counting, then peak at rated current
    i_run_cmd <= 1'b0;
    cyc(6'h01);
    i_run_cmd     <= 1'b1;
    i_out_current <= i_rated_current;
    cyc(6'h01);
    repeat (4) cyc(6'h00);
    `CHK("peak_analog", mmb_pkg::ANALOG_FS, o_peak_analog)
    i_out_current <= 16'h0001;
    cyc(6'h00);
    check_all;
    $display("test run_condition_peak done");
    // Mid-run reset drops the held peak; half rated current gives half range
    i_rst_n <= 1'b0;
    cyc(6'h00);
    peak = 0;
    i_rst_n       <= 1'b1;
    i_out_current <= i_rated_current >> 1;
    repeat (3) cyc(6'h00);
    `CHK("peak_analog_half", 32'(peak * mmb_pkg::ANALOG_FS / i_rated_current), 32'(o_peak_analog))
    bus({19'h0, mmb_pkg::IDX_PEAK_CURRENT_HOLD, 2'h0}, 1'b0, 32'h0);
    `CHK("peak_after_reset", 32'(peak), rd)
    $display("test mid_reset_peak done");
    conclude;
  end
endmodule // mmb_monitor_bank_tb
